// ==== core/dimm_top.v ====
// Digital input conditioning, image refresh, APB registers and Modbus answers
`timescale 1ns/1ps
`include "dimm_consts.vh"
module dimm_top #(
    parameter NCH = 15,
    parameter [23:0] SNAP_CYCLES = `DIMM_SNAP_PERIOD_US * `DIMM_CLK_KHZ / 1000,
    parameter [23:0] MS_CYCLES = `DIMM_MS_TICK_US * `DIMM_CLK_KHZ / 1000
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Field inputs
    input wire [NCH-1:0] field_in,
    input wire [NCH-1:0] field_fault,
    // Modbus request from the communication unit
    input wire mb_req,
    input wire [7:0] mb_func,
    input wire [15:0] mb_addr,
    input wire mb_legacy,
    output reg mb_rsp_valid,
    output reg [15:0] mb_rsp_data,
    output reg [7:0] mb_rsp_exc,
    // Communication image
    output reg [14:0] img_values,
    output reg [15:0] img_status,
    output reg img_update,
    // Interrupt
    output reg irq
);
    localparam CW = `DIMM_CFG_W;
    localparam EW = `DIMM_EV_W;

    // Software settings
    reg [7:0] slot;
    reg [15:0] bit_base;
    reg [15:0] word_base;
    reg [EW-1:0] irq_stat;
    reg [EW-1:0] irq_en;
    wire [NCH*CW-1:0] cfg_flat;

    // Timing
    reg [23:0] ms_cnt;
    reg [23:0] snap_cnt;
    reg ms_tick;
    reg snap_tick;

    // Conditioned channels
    wire [NCH-1:0] cond_val;
    wire [NCH-1:0] cond_bad;
    wire coll;

    // APB decode
    wire acc;
    wire wr_done;
    wire [11:0] ch_off;
    wire [3:0] ch_idx;
    wire ch_hit;
    reg [31:0] next_prdata;
    reg next_pslverr;

    // Interrupt next state
    wire [EW-1:0] ev;
    wire [EW-1:0] clr;
    wire [EW-1:0] next_irq_stat;

    // Modbus decode result
    wire [15:0] dec_data;
    wire [7:0] dec_exc;

    assign acc = psel && penable;
    assign wr_done = acc && pready && pwrite;
    assign ch_off = paddr - `DIMM_REG_CH_BASE;
    assign ch_idx = ch_off[5:2];
    assign ch_hit = (paddr >= `DIMM_REG_CH_BASE) && (ch_off[11:6] == 6'h00) &&
        ({28'h0000000, ch_idx} < NCH) && (paddr[1:0] == 2'h0);

    // Millisecond and refresh timebases
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= 24'h000000;
            ms_tick <= 1'b0;
        end else if (ms_cnt == MS_CYCLES - 24'h000001) begin
            ms_cnt <= 24'h000000;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 24'h000001;
            ms_tick <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_cnt <= 24'h000000;
            snap_tick <= 1'b0;
        end else if (snap_cnt == SNAP_CYCLES - 24'h000001) begin
            snap_cnt <= 24'h000000;
            snap_tick <= 1'b1;
        end else begin
            snap_cnt <= snap_cnt + 24'h000001;
            snap_tick <= 1'b0;
        end
    end

    // Channels: each keeps its own settings, filter and last valid value
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : chan
            reg [CW-1:0] cfg;
            reg last_ok;
            wire filt;
            wire lvl;
            wire [1:0] mode;
            wire fault_val;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg <= `DIMM_CFG_RESET;
                end else if (wr_done && ch_hit && ch_idx == g) begin
                    cfg <= pwdata[CW-1:0];
                end
            end
            assign cfg_flat[g*CW +: CW] = cfg;

            dimm_chan_filter #(
                .DW(8)
            ) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .ms_tick(ms_tick),
                .on_ms(cfg[`DIMM_CFG_ON_LSB +: 8]),
                .off_ms(cfg[`DIMM_CFG_OFF_LSB +: 8]),
                .raw_in(field_in[g]),
                .filt_out(filt)
            );

            assign lvl = filt ^ cfg[`DIMM_CFG_INV];

            // remember last value seen without fault
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    last_ok <= 1'b0;
                end else if (!field_fault[g]) begin
                    last_ok <= lvl;
                end
            end

            assign mode = cfg[`DIMM_CFG_ERR_LSB +: 2];
            assign fault_val = (mode == `DIMM_ERR_SUBST) ? cfg[`DIMM_CFG_SUBST] :
                (mode == `DIMM_ERR_LAST) ? last_ok : lvl;

            assign cond_val[g] = cfg[`DIMM_CFG_SIM] ? cfg[`DIMM_CFG_SIM_VAL] :
                (field_fault[g] ? fault_val : lvl);
            assign cond_bad[g] = cfg[`DIMM_CFG_SIM] ? cfg[`DIMM_CFG_SIM_BAD] : field_fault[g];
        end
    endgenerate

    assign coll = |cond_bad;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            img_values <= 15'h0000;
            img_status <= 16'h0000;
            img_update <= 1'b0;
        end else begin
            img_update <= snap_tick;
            if (snap_tick) begin
                img_values <= cond_val[14:0];
                img_status <= {coll, cond_bad[14:0]};
            end
        end
    end

    // Interrupt events derived from the refresh
    assign ev[`DIMM_EV_SNAP] = snap_tick;
    assign ev[`DIMM_EV_COLL] = snap_tick && coll && !img_status[15];
    assign ev[`DIMM_EV_CHANGE] = snap_tick && (cond_val[14:0] != img_values);
    assign clr = (wr_done && paddr == `DIMM_REG_IRQ_CLR) ? pwdata[EW-1:0] : {EW{1'b0}};
    // Set wins over a clear in the same cycle
    assign next_irq_stat = (irq_stat & ~clr) | ev;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= {EW{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_en);
        end
    end

    // Module-wide settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot <= 8'h00;
            bit_base <= 16'h0000;
            word_base <= 16'h0000;
            irq_en <= {EW{1'b0}};
        end else if (wr_done) begin
            case (paddr)
                `DIMM_REG_SLOT: begin
                    slot <= pwdata[7:0];
                end
                `DIMM_REG_BIT_BASE: begin
                    bit_base <= pwdata[15:0];
                end
                `DIMM_REG_WORD_BASE: begin
                    word_base <= pwdata[15:0];
                end
                `DIMM_REG_IRQ_EN: begin
                    irq_en <= pwdata[EW-1:0];
                end
                default: begin
                    irq_en <= irq_en;
                end
            endcase
        end
    end

    // Read mux; clear register is write-only and reads zero
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (ch_hit) begin
            next_prdata = {{(32-CW){1'b0}}, cfg_flat[ch_idx*CW +: CW]};
        end else begin
            case (paddr)
                `DIMM_REG_SLOT: begin
                    next_prdata = {24'h000000, slot};
                end
                `DIMM_REG_BIT_BASE: begin
                    next_prdata = {16'h0000, bit_base};
                end
                `DIMM_REG_WORD_BASE: begin
                    next_prdata = {16'h0000, word_base};
                end
                `DIMM_REG_VALUES: begin
                    next_prdata = {17'h00000, img_values};
                end
                `DIMM_REG_STATUS: begin
                    next_prdata = {16'h0000, img_status};
                end
                `DIMM_REG_IRQ_STAT: begin
                    next_prdata = {{(32-EW){1'b0}}, irq_stat};
                end
                `DIMM_REG_IRQ_CLR: begin
                    next_prdata = 32'h00000000;
                end
                `DIMM_REG_IRQ_EN: begin
                    next_prdata = {{(32-EW){1'b0}}, irq_en};
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // One wait state: answer prepared, then pready for one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (acc && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // answers drawn from the image only
    dimm_mb_decode u_dec (
        .func(mb_func),
        .addr(mb_addr),
        .legacy(mb_legacy),
        .slot(slot),
        .bit_base(bit_base),
        .word_base(word_base),
        .values(img_values),
        .status(img_status),
        .data(dec_data),
        .exc(dec_exc)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mb_rsp_valid <= 1'b0;
            mb_rsp_data <= 16'h0000;
            mb_rsp_exc <= `DIMM_EXC_NONE;
        end else begin
            mb_rsp_valid <= mb_req;
            if (mb_req) begin
                mb_rsp_data <= dec_data;
                mb_rsp_exc <= dec_exc;
            end
        end
    end
endmodule

// ==== core/dimm_consts.vh ====
// Constants for the digital input conditioning and Modbus map block
`ifndef DIMM_CONSTS_VH
`define DIMM_CONSTS_VH

// APB register byte offsets
`define DIMM_REG_SLOT 12'h000
`define DIMM_REG_BIT_BASE 12'h004
`define DIMM_REG_WORD_BASE 12'h008
`define DIMM_REG_VALUES 12'h00c
`define DIMM_REG_STATUS 12'h010
`define DIMM_REG_IRQ_STAT 12'h014
`define DIMM_REG_IRQ_CLR 12'h018
`define DIMM_REG_IRQ_EN 12'h01c
`define DIMM_REG_CH_BASE 12'h040

// Channel setting fields
`define DIMM_CFG_ON_LSB 0
`define DIMM_CFG_OFF_LSB 8
`define DIMM_CFG_INV 16
`define DIMM_CFG_SIM 17
`define DIMM_CFG_SIM_VAL 18
`define DIMM_CFG_SIM_BAD 19
`define DIMM_CFG_ERR_LSB 20
`define DIMM_CFG_SUBST 22
`define DIMM_CFG_W 23
`define DIMM_CFG_RESET 23'h000000

// Error strategies
`define DIMM_ERR_CURRENT 2'h0
`define DIMM_ERR_SUBST 2'h1
`define DIMM_ERR_LAST 2'h2

// Interrupt event bits
`define DIMM_EV_SNAP 0
`define DIMM_EV_COLL 1
`define DIMM_EV_CHANGE 2
`define DIMM_EV_W 3

// Timing
`define DIMM_CLK_KHZ 100000
`define DIMM_SNAP_PERIOD_US 6500
`define DIMM_MS_TICK_US 1000

// Modbus address bases, direct and legacy style
`define DIMM_DIRECT_BIT 16'h0000
`define DIMM_LS_BIT 16'h2711
`define DIMM_DIRECT_WORD 16'h0400
`define DIMM_LS_WORD 16'hb3b1
`define DIMM_DIRECT_SLOT 16'h1400
`define DIMM_LS_SLOT 16'h3e81
`define DIMM_DIRECT_MSTAT 16'h0800
`define DIMM_LS_MSTAT 16'h36b1

// Modbus function and exception codes
`define DIMM_FC_BITS 8'h02
`define DIMM_FC_WORDS 8'h03
`define DIMM_EXC_NONE 8'h00
`define DIMM_EXC_FUNC 8'h01
`define DIMM_EXC_ADDR 8'h02

`endif

// ==== core/dimm_chan_filter.v ====
// ON/OFF delay filter for one digital input channel
`timescale 1ns/1ps
module dimm_chan_filter #(
    parameter DW = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Millisecond tick and delays
    input wire ms_tick,
    input wire [DW-1:0] on_ms,
    input wire [DW-1:0] off_ms,
    // Signal
    input wire raw_in,
    output reg filt_out
);
    localparam [DW-1:0] ONE = 1;
    reg [DW-1:0] cnt;
    wire [DW-1:0] limit;

    assign limit = raw_in ? on_ms : off_ms;

    // Partial first millisecond: delay accurate to within one tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= {DW{1'b0}};
            filt_out <= 1'b0;
        end else if (raw_in == filt_out) begin
            cnt <= {DW{1'b0}};
        end else if (cnt >= limit) begin
            filt_out <= raw_in;
            cnt <= {DW{1'b0}};
        end else if (ms_tick) begin
            cnt <= cnt + ONE;
        end
    end
endmodule

// ==== core/dimm_mb_decode.v ====
// Modbus address decode and answer for the input image
`timescale 1ns/1ps
`include "dimm_consts.vh"
module dimm_mb_decode (
    // Request
    input wire [7:0] func,
    input wire [15:0] addr,
    input wire legacy,
    // Map settings
    input wire [7:0] slot,
    input wire [15:0] bit_base,
    input wire [15:0] word_base,
    // Image
    input wire [14:0] values,
    input wire [15:0] status,
    // Answer
    output reg [15:0] data,
    output reg [7:0] exc
);
    wire [31:0] img;
    wire [15:0] slot_base;
    wire [15:0] mstat_base;
    wire [15:0] alloc_base;
    wire [15:0] wbase;
    wire [15:0] abs_bit;
    wire [15:0] abs_word;
    wire bad_bit;
    wire bad_word;
    wire [15:0] o_slot;
    wire [15:0] o_mstat;
    wire [15:0] o_alloc;

    assign img = {status, 1'b0, values};
    assign slot_base = `DIMM_DIRECT_SLOT + {4'h0, slot, 4'h0};
    assign mstat_base = `DIMM_DIRECT_MSTAT + {5'h00, slot, 3'h0};
    assign alloc_base = `DIMM_DIRECT_BIT + bit_base;
    assign wbase = `DIMM_DIRECT_WORD + word_base;
    assign abs_bit = !legacy ? addr :
        (addr >= `DIMM_LS_SLOT) ? addr - `DIMM_LS_SLOT + `DIMM_DIRECT_SLOT :
        (addr >= `DIMM_LS_MSTAT) ? addr - `DIMM_LS_MSTAT + `DIMM_DIRECT_MSTAT :
        addr - `DIMM_LS_BIT + `DIMM_DIRECT_BIT;
    assign bad_bit = legacy && (addr < `DIMM_LS_BIT);
    assign abs_word = legacy ? addr - `DIMM_LS_WORD + `DIMM_DIRECT_WORD : addr;
    assign bad_word = legacy && (addr < `DIMM_LS_WORD);
    assign o_slot = abs_bit - slot_base;
    assign o_mstat = abs_bit - mstat_base;
    assign o_alloc = abs_bit - alloc_base;

    always @* begin
        data = 16'h0000;
        exc = `DIMM_EXC_ADDR;
        if (func == `DIMM_FC_BITS) begin
            if (bad_bit) begin
                exc = `DIMM_EXC_ADDR;
            end else if (abs_bit >= slot_base && o_slot < 16'h0020) begin
                data = {15'h0000, img[o_slot[4:0]]};
                exc = `DIMM_EXC_NONE;
            end else if (abs_bit >= mstat_base && o_mstat < 16'h0008) begin
                data = {15'h0000, (o_mstat[2:0] == 3'h0) ? status[15] : 1'b0};
                exc = `DIMM_EXC_NONE;
            end else if (abs_bit >= alloc_base && o_alloc < 16'h0020) begin
                data = {15'h0000, img[o_alloc[4:0]]};
                exc = `DIMM_EXC_NONE;
            end
        end else if (func == `DIMM_FC_WORDS) begin
            if (!bad_word && abs_word == wbase) begin
                data = {1'b0, values};
                exc = `DIMM_EXC_NONE;
            end else if (!bad_word && abs_word == wbase + 16'h0001) begin
                data = status;
                exc = `DIMM_EXC_NONE;
            end
        end else begin
            exc = `DIMM_EXC_FUNC;
        end
    end
endmodule

// ==== core/dimm_top_end_marker_unused.v ====
`timescale 1ns/1ps

// ==== tb/dimm_monitor.sv ====
// Concurrent checks on the ports of the digital input map block
`timescale 1ns/1ps
module dimm_monitor #(
    parameter [23:0] SNAP_CYCLES = 24'h000014
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Register bus answer
    input wire pready,
    input wire pslverr,
    // Modbus
    input wire mb_req,
    input wire [7:0] mb_func,
    input wire mb_rsp_valid,
    input wire [15:0] mb_rsp_data,
    input wire [7:0] mb_rsp_exc,
    // Image
    input wire [14:0] img_values,
    input wire [15:0] img_status,
    input wire img_update
);
    reg [23:0] gap;
    reg seen;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the last refresh, so the period can be pinned exactly
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 24'h000000;
            seen <= 1'b0;
        end else begin
            gap <= img_update ? 24'h000000 : gap + 24'h000001;
            seen <= seen | img_update;
        end
    end
    a_mb_answer: assert property (mb_req |=> mb_rsp_valid) else $error("answer missing");
    a_mb_quiet: assert property (!mb_req |=> !mb_rsp_valid) else $error("answer without request");
    a_write_refused: assert property (mb_req && mb_func != 8'h02 && mb_func != 8'h03 |=> mb_rsp_exc == 8'h01)
        else $error("function not refused");
    a_answer_held: assert property (!mb_req |=> $stable(mb_rsp_data) && $stable(mb_rsp_exc))
        else $error("answer changed without request");
    a_coll_flag: assert property (img_status[15] == |img_status[14:0]) else $error("collective flag wrong");
    a_image_held: assert property (!img_update |-> $stable(img_values) && $stable(img_status))
        else $error("image changed outside refresh");
    a_snap_period: assert property (img_update && seen |-> gap == SNAP_CYCLES - 24'h000001)
        else $error("refresh period wrong");
    a_snap_alive: assert property (seen |-> gap < SNAP_CYCLES) else $error("refresh overdue");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
endmodule

// ==== tb/dimm_mb_master.sv ====
// Modbus master model issuing single reads to the block
`timescale 1ns/1ps
module dimm_mb_master (
    // Clock
    input wire pclk,
    // Request
    output reg mb_req,
    output reg [7:0] mb_func,
    output reg [15:0] mb_addr,
    output reg mb_legacy,
    // Answer
    input wire mb_rsp_valid,
    input wire [15:0] mb_rsp_data,
    input wire [7:0] mb_rsp_exc
);
    initial begin
        mb_req = 1'b0;
        mb_func = 8'h00;
        mb_addr = 16'h0000;
        mb_legacy = 1'b0;
    end
    // one read request, answer taken when valid
    task query(input [7:0] f, input [15:0] a, input l, output [15:0] d, output [7:0] x);
        integer n;
        begin
            mb_req <= 1'b1;
            mb_func <= f;
            mb_addr <= a;
            mb_legacy <= l;
            d = 16'hdead;
            x = 8'hff;
            for (n = 0; n < 8; n = n + 1) begin
                @(posedge pclk);
                if (mb_rsp_valid === 1'b1) begin
                    d = mb_rsp_data;
                    x = mb_rsp_exc;
                    n = 8;
                end
            end
            mb_req <= 1'b0;
            // Released lines carry garbage so a late decode is caught
            mb_func <= ~f;
            mb_addr <= ~a;
            mb_legacy <= ~l;
            @(posedge pclk);
        end
    endtask
endmodule

// ==== tb/digital_input_modbus_map_bench.sv ====
// Self-checking bench for the digital input map block
`timescale 1ns/1ps
`include "dimm_consts.vh"
`define CHK(a, b) begin comparisons = comparisons + 1; if ((a) !== (b)) begin bad_count = bad_count + 1; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module digital_input_modbus_map_bench;
    localparam [23:0] SNAP = 24'h000014;
    localparam [11:0] RA [0:7] = '{`DIMM_REG_SLOT, `DIMM_REG_BIT_BASE, `DIMM_REG_WORD_BASE, `DIMM_REG_IRQ_EN,
        `DIMM_REG_IRQ_CLR, `DIMM_REG_CH_BASE, 12'h020, 12'h002};
    localparam [7:0] BADF [0:5] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [14:0] fin = 15'h0000;
    reg [14:0] fflt = 15'h0000;
    wire [31:0] prdata;
    wire pready, pslverr, mb_req, mb_legacy, mb_rsp_valid, img_update, irq;
    wire [7:0] mb_func, mb_rsp_exc;
    wire [15:0] mb_addr, mb_rsp_data;
    wire [14:0] img_values;
    wire [15:0] img_status;
    integer bad_count = 0;
    integer comparisons = 0;
    integer i, k, s, sl, bb, wb;
    reg [31:0] seed = 32'h4546;
    reg [31:0] r, im;
    reg [22:0] cfg [0:14];
    reg [14:0] ev, lastv;
    reg [15:0] es, d;
    reg [7:0] x;
    reg [4:0] b;
    reg [2:0] m;
    reg e;
    always #5 pclk = ~pclk;
    dimm_top #(.SNAP_CYCLES(SNAP), .MS_CYCLES(24'h000004)) u_dimm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .field_in(fin), .field_fault(fflt), .mb_req(mb_req), .mb_func(mb_func),
        .mb_addr(mb_addr), .mb_legacy(mb_legacy), .mb_rsp_valid(mb_rsp_valid), .mb_rsp_data(mb_rsp_data),
        .mb_rsp_exc(mb_rsp_exc), .img_values(img_values), .img_status(img_status), .img_update(img_update),
        .irq(irq));
    dimm_mb_master u_dimm_mb_master (.pclk(pclk), .mb_req(mb_req), .mb_func(mb_func), .mb_addr(mb_addr),
        .mb_legacy(mb_legacy), .mb_rsp_valid(mb_rsp_valid), .mb_rsp_data(mb_rsp_data), .mb_rsp_exc(mb_rsp_exc));
    function [31:0] rnd(input [31:0] unused);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task tick(input integer n);
        integer j;
        begin
            for (j = 0; j < n; j = j + 1)
                @(posedge pclk);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] wd);
        integer j;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            for (j = 0; j < 16; j = j + 1) begin
                @(posedge pclk);
                if (pready === 1'b1) begin
                    r = prdata;
                    e = pslverr;
                    j = 99;
                end
            end
            if (j == 16) begin
                bad_count = bad_count + 1;
                wrap_up;
            end
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task wait_img;
        integer j;
        begin
            j = 0;
            do begin
                @(posedge pclk);
                j = j + 1;
            end while (img_update !== 1'b1 && j < 64);
            if (j == 64) begin
                bad_count = bad_count + 1;
                wrap_up;
            end
        end
    endtask
    task settle;
        repeat (4) wait_img;
    endtask
    task mbq(input [7:0] f, input [15:0] a, input l, input [15:0] ed, input [7:0] ex);
        begin
            u_dimm_mb_master.query(f, a, l, d, x);
            if (x === 8'hff) begin
                bad_count = bad_count + 1;
                wrap_up;
            end
            if (ex != `DIMM_EXC_FUNC) `CHK(d, ed)
            `CHK(x, ex)
        end
    endtask
    // Last valid level follows the field, inverted where the channel's invert bit is set, while the channel is healthy
    task track_last;
        for (i = 0; i < 15; i = i + 1)
            if (!fflt[i]) lastv[i] = fin[i] ^ cfg[i][`DIMM_CFG_INV];
    endtask
    // expected value and status of every channel
    task model;
        begin
            for (i = 0; i < 15; i = i + 1) begin
                es[i] = cfg[i][`DIMM_CFG_SIM] ? cfg[i][`DIMM_CFG_SIM_BAD] : fflt[i];
                ev[i] = fin[i] ^ cfg[i][`DIMM_CFG_INV];
                if (cfg[i][`DIMM_CFG_SIM]) ev[i] = cfg[i][`DIMM_CFG_SIM_VAL];
                else if (fflt[i] && cfg[i][21:20] == `DIMM_ERR_SUBST) ev[i] = cfg[i][`DIMM_CFG_SUBST];
                else if (fflt[i] && cfg[i][21:20] == `DIMM_ERR_LAST) ev[i] = lastv[i];
            end
            es[15] = |es[14:0];
        end
    endtask
    task pulse(input v, input ex);
        begin
            fin[0] <= v;
            tick(24);
            fin[0] <= ~v;
            repeat (3) begin
                wait_img;
                `CHK(img_values[0], ex)
            end
        end
    endtask
    initial begin
        lastv = 15'h0000;
        tick(4);
        presetn <= 1'b1;
        tick(1);
        for (i = 0; i < 8; i = i + 1) begin
            apb(1'b0, RA[i], 32'h0);
            `CHK(r, 32'h0)
            `CHK(e, i > 5)
        end
        s = rnd(0);
        sl = s[2:0];
        bb = s[15:8];
        wb = s[23:16];
        apb(1'b1, `DIMM_REG_SLOT, sl);
        apb(1'b1, `DIMM_REG_BIT_BASE, bb);
        apb(1'b1, `DIMM_REG_WORD_BASE, wb);
        apb(1'b0, `DIMM_REG_BIT_BASE, 32'h0);
        `CHK(r, bb)
        $display("test registers done");
        // own settings per channel, every error strategy, simulation on the top three
        for (i = 0; i < 15; i = i + 1) begin
            s = rnd(0);
            cfg[i] = {s[22], i[1:0], s[19:18], i > 11, s[16], 16'h0000};
            apb(1'b1, `DIMM_REG_CH_BASE + 4 * i, cfg[i]);
        end
        for (k = 0; k < 12; k = k + 1) begin
            s = rnd(0);
            fin <= k == 0 ? 15'h0000 : s[14:0];
            tick(8);
            track_last;
            s = rnd(0);
            fflt <= k == 0 ? 15'h0000 : s[14:0] & s[29:15];
            wait_img;
            wait_img;
            model;
            `CHK(img_values, ev)
            `CHK(img_status, es)
            apb(1'b1, `DIMM_REG_VALUES, 32'hffffffff);
            apb(1'b0, `DIMM_REG_VALUES, 32'h0);
            `CHK(r, {17'h0, ev})
            apb(1'b0, `DIMM_REG_STATUS, 32'h0);
            `CHK(r, {16'h0, es})
            im = {es, 1'b0, ev};
            s = rnd(0);
            b = s[4:0];
            m = s[7:5];
            mbq(`DIMM_FC_BITS, `DIMM_DIRECT_SLOT + 16 * sl + b, 1'b0, im[b], `DIMM_EXC_NONE);
            mbq(`DIMM_FC_BITS, `DIMM_LS_SLOT + 16 * sl + b, 1'b1, im[b], `DIMM_EXC_NONE);
            mbq(`DIMM_FC_BITS, `DIMM_DIRECT_MSTAT + 8 * sl + m, 1'b0, es[15] & (m == 0), `DIMM_EXC_NONE);
            mbq(`DIMM_FC_BITS, `DIMM_LS_MSTAT + 8 * sl + m, 1'b1, es[15] & (m == 0), `DIMM_EXC_NONE);
            mbq(`DIMM_FC_BITS, `DIMM_DIRECT_BIT + bb + b, 1'b0, im[b], `DIMM_EXC_NONE);
            mbq(`DIMM_FC_BITS, `DIMM_LS_BIT + bb + b, 1'b1, im[b], `DIMM_EXC_NONE);
            mbq(`DIMM_FC_WORDS, `DIMM_DIRECT_WORD + wb, 1'b0, {1'b0, ev}, `DIMM_EXC_NONE);
            mbq(`DIMM_FC_WORDS, `DIMM_LS_WORD + wb + 1, 1'b1, es, `DIMM_EXC_NONE);
            mbq(`DIMM_FC_WORDS, `DIMM_DIRECT_WORD + wb + 2, 1'b0, 16'h0000, `DIMM_EXC_ADDR);
            mbq(`DIMM_FC_BITS, 16'h0fa0, 1'b0, 16'h0000, `DIMM_EXC_ADDR);
            mbq(`DIMM_FC_BITS, 16'h0fa0, 1'b1, 16'h0000, `DIMM_EXC_ADDR);
            mbq(BADF[k % 6], `DIMM_DIRECT_BIT + bb, 1'b0, 16'h0000, `DIMM_EXC_FUNC);
            track_last;
        end
        $display("test rounds done");
        // both delays 8 ms on channel 0, pulses last 6 ms
        apb(1'b1, `DIMM_REG_CH_BASE, 32'h00000808);
        fflt <= 15'h0000;
        fin[0] <= 1'b0;
        settle;
        pulse(1'b1, 1'b0);
        fin[0] <= 1'b1;
        settle;
        `CHK(img_values[0], 1'b1)
        pulse(1'b0, 1'b1);
        fin[0] <= 1'b0;
        settle;
        `CHK(img_values[0], 1'b0)
        $display("test delays done");
        for (i = 12; i < 15; i = i + 1)
            apb(1'b1, `DIMM_REG_CH_BASE + 4 * i, 32'h0);
        apb(1'b1, `DIMM_REG_IRQ_EN, 32'h1);
        settle;
        `CHK(irq, 1'b1)
        apb(1'b1, `DIMM_REG_IRQ_EN, 32'h0);
        tick(2);
        `CHK(irq, 1'b0)
        wait_img;
        apb(1'b1, `DIMM_REG_IRQ_CLR, 32'h7);
        fflt <= 15'h0001;
        wait_img;
        apb(1'b0, `DIMM_REG_IRQ_STAT, 32'h0);
        `CHK(r, 32'h3)
        wait_img;
        apb(1'b1, `DIMM_REG_IRQ_CLR, 32'h7);
        fin[1] <= ~fin[1];
        wait_img;
        apb(1'b0, `DIMM_REG_IRQ_STAT, 32'h0);
        `CHK(r, 32'h5)
        apb(1'b1, `DIMM_REG_IRQ_EN, 32'h4);
        tick(2);
        `CHK(irq, 1'b1)
        apb(1'b1, `DIMM_REG_IRQ_CLR, 32'h7);
        tick(2);
        `CHK(irq, 1'b0)
        $display("test interrupts done");
        wrap_up;
    end
endmodule
bind dimm_top dimm_monitor #(.SNAP_CYCLES(SNAP_CYCLES)) u_dimm_monitor (.pclk(pclk), .presetn(presetn),
    .pready(pready), .pslverr(pslverr), .mb_req(mb_req), .mb_func(mb_func), .mb_rsp_valid(mb_rsp_valid),
    .mb_rsp_data(mb_rsp_data), .mb_rsp_exc(mb_rsp_exc), .img_values(img_values), .img_status(img_status),
    .img_update(img_update));
